// ==== fifo_limits_pkg.sv ====
// Constants and types for the sample FIFO status and readout block.
// Assumes 24-bit register words addressed by a byte-wide register address.
package fifo_limits_pkg;
  localparam logic [7:0] limit_values_addr = 8'h3C;
  localparam logic [7:0] read_port_addr = 8'h3D;
  localparam logic [23:0] limit_values_reset = 24'hFFF000;
  localparam logic [23:0] read_port_reset = 24'h000000;
  localparam int upper_msb = 23;
  localparam int upper_lsb = 12;
  localparam int lower_msb = 11;
  localparam int lower_lsb = 0;
  localparam int sample_msb = 23;
  localparam int sample_lsb = 12;
  localparam int empty_bit = 0;
  localparam int watermark_bit = 1;
  localparam int overflow_bit = 2;
  localparam int lower_hit_bit = 3;
  localparam int upper_hit_bit = 4;
  localparam int status_width = 5;
  localparam logic [4:0] status_reset = 5'h01;

  typedef struct packed {
    logic [3:0] channel;
    logic [23:0] data;
  } sample_type;

  typedef struct packed {
    logic upper_limit_hit;
    logic lower_limit_hit;
    logic overflow_loss;
    logic watermark;
    logic no_entries;
  } status_type;
endpackage

// ==== sample_fifo.sv ====
// Sample FIFO with width and depth parameters and optional drop-oldest.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module sample_fifo #(
  parameter int width = 28,
  parameter int depth = 32,
  parameter int aw = $clog2(depth)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic flush,
  input wire logic drop_oldest,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data,
  // Status
  output logic [aw:0] level,
  output logic dropped
);
  // Refuse depths that the pointer arithmetic cannot serve
  if (depth < 2 || (1 << aw) != depth) begin : g_bad_depth
    $error("depth must be a power of two, at least 2");
  end

  logic [width-1:0] mem [depth];
  logic [aw:0] wr_q;
  logic [aw:0] rd_q;
  logic full;
  logic push;
  logic pop;
  logic drop;

  assign level = wr_q - rd_q;
  assign full = level == (aw+1)'(depth);
  assign out_valid = level != '0;
  assign in_ready = !full || drop_oldest;
  assign push = in_valid && in_ready;
  assign drop = push && full && !out_ready;
  assign pop = (out_valid && out_ready) || drop;
  assign dropped = drop;
  assign out_data = mem[rd_q[aw-1:0]];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q[aw-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'h1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'h1;
      end
    end
  end
endmodule

// ==== fifo_flags_threshold_readout.sv ====
// Status flags, limit comparison and readout for the converter's FIFO.
// Assumes a register access port decoded from the serial host interface.
// Notes on behaviour
// - Watermark flag high when enabled and stored count at least watermark, else low.
// - Each flag's interrupt follows its flag in the same cycle.
// - No-entries flag clears once at least one entry is stored.
// - Enabled channel sample at or above upper limit sets upper hit.
// - Enabled channel sample at or below lower limit sets lower hit.
// - Reading address 0x3D pops and returns a 24-bit stored word.
// - Limits live in one read/write register at 0x3C, reset 0xFFF000.
// - Streaming mode on full FIFO drops oldest and sets overflow.
// - Limit hits and overflow clear when the FIFO is emptied.
`timescale 1ns/1ps
module fifo_flags_threshold_readout #(
  parameter int depth = 32,
  parameter int channels = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic fifo_enable,
  input wire logic streaming_mode,
  input wire logic clear_cmd,
  input wire logic [$clog2(depth):0] watermark,
  input wire logic [channels-1:0] channel_limit_check_enable,
  // Conversion input
  input wire logic sample_valid,
  output logic sample_ready,
  input wire fifo_limits_pkg::sample_type sample_in,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  output logic [23:0] reg_rdata,
  // Status and interrupts
  output fifo_limits_pkg::status_type status,
  output logic [fifo_limits_pkg::status_width-1:0] status_irq
);
  localparam int aw = $clog2(depth);

  // All checks below run on the register clock and sleep in reset
  default clocking assert_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // The channel field is four bits wide, so at most sixteen enables
  if (channels < 1 || channels > 16) begin : g_bad_channels
    $error("channels must be 1 to 16");
  end

  logic [23:0] limits_q;
  logic [23:0] rdata_q;
  logic [11:0] upper_limit_value;
  logic [11:0] lower_limit_value;
  fifo_limits_pkg::sample_type head;
  logic head_valid;
  logic pop;
  logic flush;
  logic dropped;
  logic [aw:0] level;
  logic push_ready;
  logic push;
  logic [11:0] sample_top;
  logic check_on;
  logic upper_q;
  logic lower_q;
  logic overflow_q;
  logic emptied;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  assign flush = clear_cmd || !fifo_enable;
  assign pop = reg_rd && addr_is(reg_addr, fifo_limits_pkg::read_port_addr);
  assign push = sample_valid && push_ready && fifo_enable;
  assign sample_ready = push_ready && fifo_enable;

  sample_fifo #(.width($bits(fifo_limits_pkg::sample_type)), .depth(depth))
  u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(flush),
    .drop_oldest(streaming_mode),
    .in_valid(sample_valid && fifo_enable),
    .in_ready(push_ready),
    .in_data(sample_in),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head),
    .level(level),
    .dropped(dropped)
  );

  assign upper_limit_value = limits_q[fifo_limits_pkg::upper_msb:
                                      fifo_limits_pkg::upper_lsb];
  assign lower_limit_value = limits_q[fifo_limits_pkg::lower_msb:
                                      fifo_limits_pkg::lower_lsb];
  // Top twelve bits of the result
  assign sample_top = sample_in.data[fifo_limits_pkg::sample_msb:
                                     fifo_limits_pkg::sample_lsb];
  assign check_on = push && channel_limit_check_enable[sample_in.channel];
  // Last entry leaving, or FIFO wiped
  assign emptied = flush || (pop && head_valid && level == 1);

  // Limit register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      limits_q <= fifo_limits_pkg::limit_values_reset;
    end else if (reg_wr &&
                 addr_is(reg_addr, fifo_limits_pkg::limit_values_addr)) begin
      limits_q <= reg_wdata;
    end
  end

  // Read data, popping on the data address
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= fifo_limits_pkg::read_port_reset;
    end else if (reg_rd) begin
      if (addr_is(reg_addr, fifo_limits_pkg::limit_values_addr)) begin
        rdata_q <= limits_q;
      end else if (pop && head_valid) begin
        rdata_q <= head.data;
      end else begin
        rdata_q <= '0;
      end
    end
  end
  assign reg_rdata = rdata_q;

  // Sticky limit and overflow flags; a new event wins over emptying
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      upper_q <= 1'h0;
      lower_q <= 1'h0;
      overflow_q <= 1'h0;
    end else begin
      if (check_on && sample_top >= upper_limit_value) begin
        upper_q <= 1'h1;
      end else if (emptied) begin
        upper_q <= 1'h0;
      end
      if (check_on && sample_top <= lower_limit_value) begin
        lower_q <= 1'h1;
      end else if (emptied) begin
        lower_q <= 1'h0;
      end
      if (dropped) begin
        overflow_q <= 1'h1;
      end else if (emptied) begin
        overflow_q <= 1'h0;
      end
    end
  end

  always_comb begin
    status.upper_limit_hit = upper_q;
    status.lower_limit_hit = lower_q;
    status.overflow_loss = overflow_q;
    status.watermark = fifo_enable && level >= watermark;
    status.no_entries = !fifo_enable || level == '0;
  end
  assign status_irq = status;


  // Single-cycle conditions as named sequences
  sequence s_limit_write;
    reg_wr && addr_is(reg_addr, fifo_limits_pkg::limit_values_addr);
  endsequence
  sequence s_head_pop;
    pop && head_valid;
  endsequence
  sequence s_quiet_flush;
    flush && !check_on && !dropped;
  endsequence
  sequence s_last_pop;
    pop && head_valid && level == 1 && !push;
  endsequence

  a_limits_reset: assert property ($rose(rst_n) |->
    limits_q == fifo_limits_pkg::limit_values_reset)
    else $error("limit register reset value wrong");
  a_limits_write: assert property (s_limit_write |=>
    limits_q == $past(reg_wdata))
    else $error("limit write not stored");
  a_watermark_flag: assert property (
    status.watermark == (fifo_enable && level >= watermark))
    else $error("watermark flag wrong");
  a_irq_follow: assert property (
    status_irq == status)
    else $error("interrupt differs from flag");
  a_empty_flag: assert property (
    !fifo_enable |-> status.no_entries)
    else $error("empty flag low while disabled");
  a_drain_empty: assert property (
    s_last_pop |=> status.no_entries)
    else $error("empty flag low after last read");
  a_entry_clears: assert property (
    fifo_enable && level != '0 |-> !status.no_entries)
    else $error("empty flag high with data");
  a_upper_hit: assert property (
    check_on && sample_top >= upper_limit_value |=> upper_q)
    else $error("upper limit hit missed");
  a_lower_hit: assert property (
    check_on && sample_top <= lower_limit_value |=> lower_q)
    else $error("lower limit hit missed");
  a_overflow_set: assert property (
    dropped |=> overflow_q)
    else $error("overflow not flagged");
  a_full_refuse: assert property (
    level == depth && !streaming_mode |-> !sample_ready)
    else $error("full FIFO took a sample");
  a_flags_emptied: assert property (
    s_quiet_flush |=> !upper_q && !lower_q && !overflow_q)
    else $error("flags not cleared on empty");
  a_read_data: assert property (
    s_head_pop |=> reg_rdata == $past(head.data))
    else $error("read port data wrong");
  a_read_empty: assert property (
    pop && !head_valid |=> reg_rdata == '0)
    else $error("empty read port not zero");
  a_read_unmapped: assert property (
    reg_rd && !pop &&
    !addr_is(reg_addr, fifo_limits_pkg::limit_values_addr) |=>
    reg_rdata == '0)
    else $error("unmapped read not zero");
endmodule

// ==== host_model.sv ====
// Host model that drives the register access port.
// Assumes strobes are taken on the rising edge of ref_clk.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic ref_clk,
  // Register access
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata
);
  initial begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 24'h000000;
  end
  // Write one 24-bit word, then drop the strobe and drive inverted address and data
  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
    @(negedge ref_clk);
  endtask
  // Read one word; data is sampled at the falling edge after the taking edge
  task automatic rd(input logic [7:0] a, output logic [23:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask
endmodule

// ==== fifo_flags_threshold_readout_bench.sv ====
// Bench for the FIFO status, limit and readout block.
// Assumes host_model stands in for the host on the register port.
`timescale 1ns/1ps
module fifo_flags_threshold_readout_bench;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic fifo_enable = 1'h1;
  logic streaming_mode = 1'h0;
  logic clear_cmd = 1'h0;
  logic [5:0] watermark = 6'h02;
  logic [15:0] limit_en = 16'h0008;
  logic sample_valid = 1'h0;
  logic sample_ready;
  fifo_limits_pkg::sample_type sample_in = '0;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata, d;
  fifo_limits_pkg::status_type status;
  logic [4:0] status_irq;
  int fails = 0;
  int n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  fifo_flags_threshold_readout dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .fifo_enable(fifo_enable), .streaming_mode(streaming_mode),
    .clear_cmd(clear_cmd), .watermark(watermark),
    .channel_limit_check_enable(limit_en), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_in(sample_in), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .status(status), .status_irq(status_irq));
  host_model host_u (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic st(input logic [4:0] e);
    chk({19'h0, status}, {19'h0, e});
    chk({19'h0, status_irq}, {19'h0, status});
  endtask
  task automatic push(input logic [3:0] c, input logic [23:0] v);
    @(posedge ref_clk);
    sample_in <= '{c, v};
    sample_valid <= 1'h1;
    @(posedge ref_clk);
    sample_valid <= 1'h0;
    @(negedge ref_clk);
  endtask
  task automatic flush;
    @(posedge ref_clk);
    clear_cmd <= 1'h1;
    @(posedge ref_clk);
    clear_cmd <= 1'h0;
    @(negedge ref_clk);
  endtask
  task automatic test_reset;
    st(5'h01);
    host_u.rd(8'h3C, d);
    chk(d, 24'hFFF000);
    host_u.rd(8'h3D, d);
    chk(d, 24'h000000);
    host_u.rd(8'h10, d);
    chk(d, 24'h000000);
    $display("test_reset done");
  endtask
  task automatic test_limits;
    logic [23:0] w[4];
    w = '{24'h7FF000, 24'hFFF000, 24'h800000, 24'h100FFF};
    host_u.wr(8'h3C, 24'h800100);
    host_u.rd(8'h3C, d);
    chk(d, 24'h800100);
    flush();
    push(4'h3, w[0]);
    st(5'h00);
    push(4'h5, w[1]);
    st(5'h02);
    push(4'h3, w[2]);
    st(5'h12);
    push(4'h3, w[3]);
    st(5'h1A);
    for (int i = 0; i < 4; i++) begin
      host_u.rd(8'h3D, d);
      chk(d, w[i]);
    end
    st(5'h01);
    $display("test_limits done");
  endtask
  task automatic test_overflow;
    for (int i = 0; i < 32; i++) push(4'h0, 24'(i));
    chk({23'h0, sample_ready}, 24'h000000);
    st(5'h02);
    @(posedge ref_clk);
    streaming_mode <= 1'h1;
    push(4'h0, 24'h000020);
    st(5'h06);
    host_u.rd(8'h3D, d);
    chk(d, 24'h000001);
    flush();
    st(5'h01);
    $display("test_overflow done");
  endtask
  task automatic test_disable;
    push(4'h0, 24'h000005);
    st(5'h00);
    @(posedge ref_clk);
    fifo_enable <= 1'h0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    st(5'h01);
    @(posedge ref_clk);
    fifo_enable <= 1'h1;
    $display("test_disable done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(negedge ref_clk);
    test_reset();
    test_limits();
    test_overflow();
    test_disable();
    finish_test();
  end
  initial begin
    #20000;
    fails++;
    finish_test();
  end
endmodule
